//--- bench/tfs_flags_props.sv
// checker: port-level assertions of the flag block
`timescale 1ns/1ps
module tfs_flags_props (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire tfs_pkg::tfs_command_type command_control_register,
	input wire logic command_strobe,
	input wire logic line_power_low,
	input wire logic supply_low,
	input wire tfs_pkg::tfs_transport_type transport,
	input wire tfs_pkg::tfs_write_char_type write_char,
	input wire logic [8:0] corrected_char,
	input wire logic corrected_valid,
	input wire logic [2:0] error_class
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic fix;
	logic go;
	assign fix = transport.pe_char_valid && transport.pe_parity_error
		&& transport.pe_dead_track_valid;
	assign go = command_strobe && command_control_register.go;
	a_fix_bit: assert property (corrected_valid && $past(fix) |->
		corrected_char == ($past(transport.pe_char) ^ (9'h001 << $past(transport.pe_dead_track))))
		else $error("corrected character wrong");
	a_fix_class: assert property (corrected_valid && $past(fix)
		|=> error_class[0])
		else $error("correction did not raise class a");
	a_unsafe_go: assert property (go && !transport.medium_on_line
		&& command_control_register.code != tfs_pkg::TFS_CMD_DRIVE_CLEAR |=> ##1 error_class[1])
		else $error("off-line go did not raise class b");
	a_gap_opi: assert property (transport.long_gap |=> ##1 error_class[1])
		else $error("long gap did not raise class b");
	a_power_unsafe: assert property ((line_power_low && !supply_low) [*8] |-> error_class[1])
		else $error("power fail did not raise unsafe");
	a_pe_mark: assert property (write_char.valid && write_char.erase_mask_valid |->
		write_char.data == 9'h000 && write_char.erase_mask == 9'h164)
		else $error("pe mark character wrong");
	a_nrz_mark: assert property (write_char.valid && !write_char.erase_mask_valid |->
		write_char.data == 9'h013 || write_char.data == 9'h000)
		else $error("nrz mark character wrong");
	a_mark_start: assert property (go && transport.medium_on_line
		&& command_control_register.code == tfs_pkg::TFS_CMD_WRITE_MARK |-> ##[1:4] write_char.valid)
		else $error("mark writer did not start");
	a_upper_zero: assert property (avs_read && !avs_waitrequest
		&& (avs_address == tfs_pkg::ADDR_CONDITION || avs_address == tfs_pkg::ADDR_FAULT)
		|-> avs_readdata[31:16] == 16'h0000)
		else $error("upper register half not zero");
	a_class_any: assert property (|error_class[1:0] |-> error_class[2])
		else $error("class without fault summary");
	cover property (corrected_valid && $past(fix));
	cover property (write_char.valid && write_char.erase_mask_valid);
	cover property (go && !transport.medium_on_line);
endmodule // tfs_flags_props
bind tfs_flags tfs_flags_props u_props (.core_clk(core_clk), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .command_control_register(command_control_register),
	.command_strobe(command_strobe), .line_power_low(line_power_low), .supply_low(supply_low),
	.transport(transport), .write_char(write_char), .corrected_char(corrected_char),
	.corrected_valid(corrected_valid), .error_class(error_class));

//--- bench/tfs_flags_tb.sv
// testbench: drives the flag block and compares it with a bench model
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
`define PULSE(f) begin @(posedge core_clk); f <= 1'b1; @(posedge core_clk); f <= 1'b0; end
module tfs_flags_tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	tfs_pkg::tfs_command_type ccr;
	logic strobe, init, cclr;
	logic line_power_low = 1'b0;
	logic supply_low = 1'b0;
	tfs_pkg::tfs_transport_type tr = '0;
	tfs_pkg::tfs_write_char_type write_char;
	logic [8:0] corrected_char;
	logic corrected_valid;
	logic [2:0] error_class;
	logic busy;
	int n_mismatch = 0;
	int comparisons = 0;
	int cond = 0;
	int fault = 0;
	int pwr = 0;
	logic [31:0] seed = 32'h61;
	logic [31:0] rd;
	logic [8:0] ch;
	logic [8:0] q[$];
	always #2.5 core_clk = ~core_clk;
	tfs_flags #(.READ_TIMEOUT(50), .WRITE_TIMEOUT(10)) dut (.core_clk(core_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .command_control_register(ccr),
		.command_strobe(strobe), .initialize(init), .controller_clear(cclr),
		.line_power_low(line_power_low), .supply_low(supply_low), .transport(tr),
		.write_char(write_char), .write_mark_busy(busy), .corrected_char(corrected_char),
		.corrected_valid(corrected_valid), .error_class(error_class));
	tfs_host_model host (.core_clk(core_clk), .command_control_register(ccr),
		.command_strobe(strobe), .initialize(init), .controller_clear(cclr));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int t;
		@(posedge core_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		t = 0;
		do begin @(posedge core_clk); t++; end while (avs_waitrequest !== 1'b0 && t < 20);
		if (t >= 20) begin
			n_mismatch++;
			$display("BAD %0t bus timeout", $time);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task check_regs;
		logic [2:0] ec;
		ec = {fault != 0, (fault & 32'h6000) != 0, fault[15]};
		bus(1'b0, tfs_pkg::ADDR_CONDITION, 32'h0);
		`CHK(rd, 32'(cond))
		bus(1'b0, tfs_pkg::ADDR_FAULT, 32'h0);
		`CHK(rd, 32'(fault))
		`CHK(error_class, ec)
	endtask
	task dclr;
		host.cmd(tfs_pkg::TFS_CMD_DRIVE_CLEAR);
		cond &= 2;
		fault = pwr ? 32'h4000 : 0;
	endtask
	// collects the characters of one mark written by the block
	task mark;
		q.delete();
		host.cmd(tfs_pkg::TFS_CMD_WRITE_MARK);
		#1;
		`CHK(busy, 1'b1)
		repeat (60) begin
			@(posedge core_clk);
			#1;
			if (write_char.valid === 1'b1) q.push_back(write_char.data);
			if (write_char.valid === 1'b1 && write_char.erase_mask_valid === 1'b1)
				`CHK(write_char.erase_mask, 9'h164)
		end
		`CHK(busy, 1'b0)
	endtask
	task test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#100us;
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		test_done;
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		tr.medium_on_line <= 1'b1;
		check_regs;
		bus(1'b1, tfs_pkg::ADDR_CONDITION, 32'hffffffff);
		bus(1'b1, tfs_pkg::ADDR_FAULT, 32'hffffffff);
		check_regs;
		bus(1'b0, 4'hc, 32'h0);
		`CHK(rd, 32'hdeadbeef)
		`PULSE(tr.tape_mark_detected) cond = 4;
		check_regs;
		host.cmd(tfs_pkg::TFS_CMD_READ);
		`PULSE(tr.record_seen) cond = 0;
		check_regs;
		`PULSE(tr.tape_mark_detected) dclr;
		`PULSE(tr.start_marker_sensed) `PULSE(tr.came_on_line) cond = 3;
		check_regs;
		host.init_pulse;
		cond = 2;
		check_regs;
		`PULSE(tr.came_on_line) dclr;
		check_regs;
		host.cmd(tfs_pkg::TFS_CMD_REWIND);
		`PULSE(tr.record_seen) fault = 32'h2000;
		check_regs;
		`PULSE(tr.forward_past_marker) cond = 0;
		check_regs;
		dclr;
		`PULSE(tr.long_gap) fault = 32'h2000;
		check_regs;
		host.init_pulse;
		fault = 0;
		check_regs;
		host.cmd(tfs_pkg::TFS_CMD_READ);
		repeat (30) @(posedge core_clk);
		check_regs;
		repeat (30) @(posedge core_clk);
		fault = 32'h2000;
		check_regs;
		dclr;
		host.cmd(tfs_pkg::TFS_CMD_WRITE);
		`PULSE(tr.raw_record_seen) repeat (20) @(posedge core_clk);
		check_regs;
		host.cmd(tfs_pkg::TFS_CMD_WRITE);
		repeat (15) @(posedge core_clk);
		fault = 32'h2000;
		check_regs;
		dclr;
		tr.medium_on_line <= 1'b0;
		dclr;
		check_regs;
		for (int c = 2; c < 8; c++) begin
			host.cmd(tfs_pkg::tfs_cmd_type'(c));
			fault = 32'h4000;
			check_regs;
			host.cclr_pulse;
			fault = 0;
			check_regs;
		end
		tr.medium_on_line <= 1'b1;
		supply_low <= 1'b1;
		line_power_low <= 1'b1;
		repeat (8) @(posedge core_clk);
		check_regs;
		supply_low <= 1'b0;
		pwr = 1;
		repeat (8) @(posedge core_clk);
		fault = 32'h4000;
		check_regs;
		dclr;
		check_regs;
		line_power_low <= 1'b0;
		pwr = 0;
		repeat (6) @(posedge core_clk);
		dclr;
		check_regs;
		for (int i = 0; i < 4; i++) begin
			ch = 9'(xs());
			@(posedge core_clk);
			tr.pe_char <= ch;
			tr.pe_dead_track <= 4'(xs() % 32'd9);
			{tr.pe_char_valid, tr.pe_parity_error, tr.pe_dead_track_valid} <= 3'h7;
			@(posedge core_clk);
			{tr.pe_char_valid, tr.pe_parity_error, tr.pe_dead_track_valid} <= 3'h0;
			#1;
			`CHK(corrected_valid, 1'b1)
			`CHK(corrected_char, ch ^ (9'h001 << tr.pe_dead_track))
		end
		fault = 32'h8000;
		check_regs;
		dclr;
		bus(1'b1, tfs_pkg::ADDR_MODE, 32'h2);
		tr.nrz_crc_calc <= 8'(xs());
		@(posedge core_clk);
		tr.nrz_crc_tape <= tr.nrz_crc_calc;
		`PULSE(tr.nrz_check_valid) check_regs;
		tr.nrz_crc_tape <= ~tr.nrz_crc_calc;
		`PULSE(tr.nrz_check_valid) fault = 32'h8000;
		check_regs;
		dclr;
		check_regs;
		mark;
		`CHK(q.size(), 3)
		if (q.size() == 3) `CHK({q[0], q[1], q[2]}, {9'h013, 9'h000, 9'h013})
		bus(1'b1, tfs_pkg::ADDR_MODE, 32'h0);
		mark;
		`CHK(q.size(), 2)
		if (q.size() == 2) `CHK({q[0], q[1]}, {9'h013, 9'h013})
		bus(1'b1, tfs_pkg::ADDR_MODE, 32'h3);
		mark;
		`CHK(q.size(), 40)
		foreach (q[i]) `CHK(q[i], 9'h000)
		test_done;
	end
endmodule // tfs_flags_tb

//--- bench/tfs_host_model.sv
// host controller model: issues commands and clear pulses
`timescale 1ns/1ps
module tfs_host_model (
	input wire logic core_clk,
	output tfs_pkg::tfs_command_type command_control_register,
	output logic command_strobe,
	output logic initialize,
	output logic controller_clear
);
	initial begin
		command_control_register = '0;
		command_strobe = 1'b0;
		initialize = 1'b0;
		controller_clear = 1'b0;
	end
	// go is only ever raised with the strobe, never left standing
	task automatic cmd(input tfs_pkg::tfs_cmd_type c);
		@(posedge core_clk);
		command_control_register <= '{go: 1'b1, code: c};
		command_strobe <= 1'b1;
		@(posedge core_clk);
		command_strobe <= 1'b0;
		command_control_register <= '0;
	endtask
	task automatic init_pulse;
		@(posedge core_clk);
		initialize <= 1'b1;
		@(posedge core_clk);
		initialize <= 1'b0;
	endtask
	task automatic cclr_pulse;
		@(posedge core_clk);
		controller_clear <= 1'b1;
		@(posedge core_clk);
		controller_clear <= 1'b0;
	endtask
endmodule // tfs_host_model

//--- hw/tfs_flags.sv
// status and fault flag logic of the tape formatter with its avalon register slave
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - tape mark flag set on detect, cleared by motion
// - pe mark: 40 chars, zeros on five tracks
// - nrzi filemark: one char octal 023 plus lrc
// - nine track nrzi filemark forces crc zero
// - start marker flag held until forward past it
// - attention flag on coming on-line, cleared by clears
// - sixteen bit fault register with fixed layout
// - pe on-the-fly correction sets correctable flag
// - nrz crc mismatch sets check error flag
// - dead track plus parity error inverts that bit
// - correctable error is class a
// - go while off-line sets unsafe, except clear
// - line low without supply low sets unsafe
// - unsafe clearing depends on its cause
// - unsafe is class b
// - read or space without record in 7 s
// - write without read-after-write record in 0.7 s
// - long blank gap sets incomplete; clears clear it
// - rewind at start marker sets incomplete
// - operation incomplete is class b
module tfs_flags #(
	parameter longint READ_TIMEOUT = tfs_pkg::READ_TIMEOUT_CYCLES,
	parameter longint WRITE_TIMEOUT = tfs_pkg::WRITE_TIMEOUT_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire tfs_pkg::tfs_command_type command_control_register,
	input wire logic command_strobe,
	input wire logic initialize,
	input wire logic controller_clear,
	input wire logic line_power_low,
	input wire logic supply_low,
	input wire tfs_pkg::tfs_transport_type transport,
	output tfs_pkg::tfs_write_char_type write_char,
	output logic write_mark_busy,
	output logic [8:0] corrected_char,
	output logic corrected_valid,
	output logic [2:0] error_class
);
	// ---------------------------------------------------------------
	// power pins come from outside the clock domain
	// ---------------------------------------------------------------
	logic [2:0] line_low_sync_q;
	logic [2:0] supply_low_sync_q;
	logic line_low_q;
	logic supply_low_q;
	// a pin change counts only once two samples agree
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			line_low_sync_q <= 3'h0;
			supply_low_sync_q <= 3'h0;
			line_low_q <= 1'b0;
			supply_low_q <= 1'b0;
		end else begin
			line_low_sync_q <= {line_low_sync_q[1:0], line_power_low};
			supply_low_sync_q <= {supply_low_sync_q[1:0], supply_low};
			if (line_low_sync_q[1] == line_low_sync_q[2])
				line_low_q <= line_low_sync_q[2];
			if (supply_low_sync_q[1] == supply_low_sync_q[2])
				supply_low_q <= supply_low_sync_q[2];
		end
	end

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	logic go_cmd;
	logic drive_clear;
	logic flag_clear;
	logic motion_start;
	logic is_read_space;
	logic is_write;
	logic [1:0] mode_q;
	assign go_cmd = command_strobe && command_control_register.go;
	assign drive_clear = go_cmd && (command_control_register.code == tfs_pkg::TFS_CMD_DRIVE_CLEAR);
	assign flag_clear = drive_clear || initialize;
	assign is_read_space = (command_control_register.code == tfs_pkg::TFS_CMD_READ) ||
		(command_control_register.code == tfs_pkg::TFS_CMD_SPACE);
	assign is_write = (command_control_register.code == tfs_pkg::TFS_CMD_WRITE) ||
		(command_control_register.code == tfs_pkg::TFS_CMD_WRITE_MARK);
	// an off-line go moves no tape and arms nothing
	assign motion_start = go_cmd && transport.medium_on_line &&
		(is_read_space || is_write || command_control_register.code == tfs_pkg::TFS_CMD_REWIND);

	// ---------------------------------------------------------------
	// condition flags
	// ---------------------------------------------------------------
	logic tape_mark_seen_q;
	logic tape_start_marker_q;
	logic transport_attention_q;
	// in every flag below the set event wins over a clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			tape_mark_seen_q <= 1'b0;
		else if (transport.tape_mark_detected)
			tape_mark_seen_q <= 1'b1;
		else if (motion_start || flag_clear)
			tape_mark_seen_q <= 1'b0;
	end

	// initialize and drive clear leave this flag alone
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			tape_start_marker_q <= 1'b0;
		else if (transport.start_marker_sensed)
			tape_start_marker_q <= 1'b1;
		else if (transport.forward_past_marker)
			tape_start_marker_q <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			transport_attention_q <= 1'b0;
		else if (transport.came_on_line)
			transport_attention_q <= 1'b1;
		else if (flag_clear)
			transport_attention_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// correctable or check error, with on-the-fly repair
	// ---------------------------------------------------------------
	logic correctable_q;
	logic pe_fix;
	logic nrz_mismatch;
	// a parity error without a named dead track passes on unrepaired
	assign pe_fix = mode_q[tfs_pkg::MODE_PHASE_ENCODED] && transport.pe_char_valid &&
		transport.pe_dead_track_valid && transport.pe_parity_error;
	assign nrz_mismatch = !mode_q[tfs_pkg::MODE_PHASE_ENCODED] && transport.nrz_check_valid &&
		(transport.nrz_crc_calc != transport.nrz_crc_tape);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			correctable_q <= 1'b0;
		else if (pe_fix || nrz_mismatch)
			correctable_q <= 1'b1;
		else if (flag_clear)
			correctable_q <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			corrected_char <= 9'h000;
			corrected_valid <= 1'b0;
		end else begin
			corrected_valid <= mode_q[tfs_pkg::MODE_PHASE_ENCODED] && transport.pe_char_valid;
			if (pe_fix)
				corrected_char <= transport.pe_char ^ (9'h001 << transport.pe_dead_track);
			else
				corrected_char <= transport.pe_char;
		end
	end

	// ---------------------------------------------------------------
	// unsafe: two causes kept apart so each clears its own way
	// ---------------------------------------------------------------
	logic unsafe_offline_q;
	logic unsafe_power_q;
	logic power_fail;
	assign power_fail = line_low_q && !supply_low_q;
	// drive clear itself never raises the off-line cause
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			unsafe_offline_q <= 1'b0;
		else if (go_cmd && !transport.medium_on_line && !drive_clear)
			unsafe_offline_q <= 1'b1;
		else if (controller_clear || drive_clear)
			unsafe_offline_q <= 1'b0;
	end

	// a persisting low voltage keeps the cause alive, so no clear can win
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			unsafe_power_q <= 1'b0;
		else if (power_fail)
			unsafe_power_q <= 1'b1;
		else if (flag_clear && !line_low_q)
			unsafe_power_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// operation incomplete with record watchdog
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		TFS_WD_IDLE = 3'b001,
		TFS_WD_READ = 3'b010,
		TFS_WD_WRITE = 3'b100
	} tfs_wd_type;
	tfs_wd_type wd_q;
	// one counter serves read and write; a new read, space or write reloads it
	logic [31:0] wd_count_q;
	logic wd_expired;
	logic op_incomplete_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_q <= TFS_WD_IDLE;
			wd_count_q <= 32'h0;
		end else if (motion_start && is_read_space) begin
			wd_q <= TFS_WD_READ;
			wd_count_q <= 32'(READ_TIMEOUT - 1);
		end else if (motion_start && is_write) begin
			wd_q <= TFS_WD_WRITE;
			wd_count_q <= 32'(WRITE_TIMEOUT - 1);
		end else begin
			unique case (wd_q)
				TFS_WD_IDLE: wd_count_q <= 32'h0;
				TFS_WD_READ: begin
					if (transport.record_seen || wd_count_q == 32'h0)
						wd_q <= TFS_WD_IDLE;
					else
						wd_count_q <= wd_count_q - 32'h1;
				end
				TFS_WD_WRITE: begin
					if (transport.raw_record_seen || wd_count_q == 32'h0)
						wd_q <= TFS_WD_IDLE;
					else
						wd_count_q <= wd_count_q - 32'h1;
				end
				default: wd_q <= TFS_WD_IDLE;
			endcase
		end
	end
	// a record in the last counted cycle still beats the expiry
	assign wd_expired = (wd_count_q == 32'h0) &&
		((wd_q == TFS_WD_READ && !transport.record_seen) ||
		(wd_q == TFS_WD_WRITE && !transport.raw_record_seen));
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			op_incomplete_q <= 1'b0;
		else if (wd_expired || transport.long_gap)
			op_incomplete_q <= 1'b1;
		// rewind at the marker still counts as motion
		else if (go_cmd && command_control_register.code == tfs_pkg::TFS_CMD_REWIND &&
			tape_start_marker_q)
			op_incomplete_q <= 1'b1;
		else if (flag_clear)
			op_incomplete_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// tape mark writer
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		TFS_MK_IDLE = 4'b0001,
		TFS_MK_PE = 4'b0010,
		TFS_MK_NRZ = 4'b0100,
		TFS_MK_CHECK = 4'b1000
	} tfs_mark_type;
	tfs_mark_type mk_q;
	logic [5:0] mk_count_q;
	logic [1:0] mk_check_q;
	// a mark command while the writer runs is ignored, not queued
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mk_q <= TFS_MK_IDLE;
			mk_count_q <= 6'h0;
			mk_check_q <= 2'h0;
			write_char <= '0;
		end else begin
			write_char <= '0;
			unique case (mk_q)
				TFS_MK_IDLE: begin
					if (motion_start && command_control_register.code == tfs_pkg::TFS_CMD_WRITE_MARK)
						mk_q <= mode_q[tfs_pkg::MODE_PHASE_ENCODED] ? TFS_MK_PE : TFS_MK_NRZ;
					mk_count_q <= 6'h0;
				end
				TFS_MK_PE: begin
					write_char.valid <= 1'b1;
					// written tracks carry zeros; erased tracks are flagged apart
					write_char.data <= ~tfs_pkg::PE_MARK_ZERO_TRACKS &
						~tfs_pkg::PE_MARK_ERASED_TRACKS;
					write_char.erase_mask_valid <= 1'b1;
					write_char.erase_mask <= tfs_pkg::PE_MARK_ERASED_TRACKS;
					if (mk_count_q == 6'(tfs_pkg::PE_MARK_CHARS - 1))
						mk_q <= TFS_MK_IDLE;
					mk_count_q <= mk_count_q + 6'h1;
				end
				TFS_MK_NRZ: begin
					write_char.valid <= 1'b1;
					write_char.data <= {1'b0, tfs_pkg::NRZ_MARK_CHAR};
					mk_check_q <= mode_q[tfs_pkg::MODE_NINE_TRACK] ? 2'h2 : 2'h1;
					mk_q <= TFS_MK_CHECK;
				end
				TFS_MK_CHECK: begin
					write_char.valid <= 1'b1;
					// nine track: forced zero crc first, then lrc of the one-char record
					if (mk_check_q == 2'h2)
						write_char.data <= {1'b0, tfs_pkg::NRZ_MARK_CRC};
					else
						write_char.data <= {1'b0, tfs_pkg::NRZ_MARK_CHAR};
					mk_check_q <= mk_check_q - 2'h1;
					if (mk_check_q == 2'h1)
						mk_q <= TFS_MK_IDLE;
				end
				default: mk_q <= TFS_MK_IDLE;
			endcase
		end
	end
	assign write_mark_busy = (mk_q != TFS_MK_IDLE);

	// ---------------------------------------------------------------
	// register views
	// ---------------------------------------------------------------
	logic [15:0] condition_flags;
	logic [15:0] fault_flags;
	always_comb begin
		condition_flags = 16'h0000;
		condition_flags[tfs_pkg::COND_TAPE_MARK_SEEN] = tape_mark_seen_q;
		condition_flags[tfs_pkg::COND_TAPE_START_MARKER] = tape_start_marker_q;
		condition_flags[tfs_pkg::COND_TRANSPORT_ATTENTION] = transport_attention_q;
	end
	// lower fault bits belong to neighbouring logic and read as zero here
	always_comb begin
		fault_flags = 16'h0000;
		fault_flags[tfs_pkg::FAULT_CORRECTABLE] = correctable_q;
		fault_flags[tfs_pkg::FAULT_UNSAFE] = unsafe_offline_q || unsafe_power_q;
		fault_flags[tfs_pkg::FAULT_OP_INCOMPLETE] = op_incomplete_q;
	end
	// bit 0 class a present, bit 1 class b present, bit 2 any
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			error_class <= 3'h0;
		else begin
			error_class[0] <= correctable_q && (tfs_pkg::CLASS_CORRECTABLE == 1'b0);
			error_class[1] <= (fault_flags[tfs_pkg::FAULT_UNSAFE] && tfs_pkg::CLASS_UNSAFE) ||
				(op_incomplete_q && tfs_pkg::CLASS_OP_INCOMPLETE);
			error_class[2] <= |fault_flags;
		end
	end

	// ---------------------------------------------------------------
	// avalon slave: one wait cycle, answer on the second edge
	// ---------------------------------------------------------------
	logic ack_q;
	// read data is taken on the request edge and held through the answer
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read || avs_write) && !ack_q;
	end

	// flag registers ignore writes; only the mode register accepts them
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			mode_q <= tfs_pkg::MODE_RESET;
		else if (avs_write && ack_q && avs_address == tfs_pkg::ADDR_MODE && avs_byteenable[0])
			mode_q <= avs_writedata[1:0];
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			avs_readdata <= 32'h0;
		else if (avs_read && !ack_q) begin
			unique case (avs_address)
				tfs_pkg::ADDR_CONDITION: avs_readdata <= {16'h0, condition_flags};
				tfs_pkg::ADDR_FAULT: avs_readdata <= {16'h0, fault_flags};
				tfs_pkg::ADDR_MODE: avs_readdata <= {30'h0, mode_q};
				default: avs_readdata <= tfs_pkg::UNMAPPED_READ;
			endcase
		end
	end
endmodule // tfs_flags

//--- hw/tfs_pkg.sv
// package: register map, field positions, timing constants and carriers of the flag block
package tfs_pkg;
	// ---------------------------------------------------------------
	// register map (word aligned byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_CONDITION = 4'h0;
	localparam logic [3:0] ADDR_FAULT = 4'h4;
	localparam logic [3:0] ADDR_MODE = 4'h8;
	localparam logic [31:0] UNMAPPED_READ = 32'hdeadbeef;
	// ---------------------------------------------------------------
	// condition register fields
	// ---------------------------------------------------------------
	localparam int COND_TAPE_MARK_SEEN = 2;
	localparam int COND_TAPE_START_MARKER = 1;
	localparam int COND_TRANSPORT_ATTENTION = 0;
	// ---------------------------------------------------------------
	// fault register fields
	// ---------------------------------------------------------------
	localparam int FAULT_CORRECTABLE = 15;
	localparam int FAULT_UNSAFE = 14;
	localparam int FAULT_OP_INCOMPLETE = 13;
	localparam int FAULT_TIMING = 12;
	localparam int FAULT_NON_EXECUTABLE = 11;
	localparam int FAULT_SKEW = 10;
	localparam int FAULT_ILLEGAL_FUNCTION = 0;
	// error classes: 0 is class a, 1 is class b
	localparam logic CLASS_CORRECTABLE = 1'b0;
	localparam logic CLASS_UNSAFE = 1'b1;
	localparam logic CLASS_OP_INCOMPLETE = 1'b1;
	// mode register fields
	localparam int MODE_PHASE_ENCODED = 0;
	localparam int MODE_NINE_TRACK = 1;
	localparam logic [1:0] MODE_RESET = 2'h3;
	// ---------------------------------------------------------------
	// tape mark patterns
	// ---------------------------------------------------------------
	localparam int PE_MARK_CHARS = 40;
	// physical tracks 1..9 on bits 0..8: zeros on 1,2,4,5,8, tracks 3,6,7,9 erased
	localparam logic [8:0] PE_MARK_ZERO_TRACKS = 9'h09b;
	localparam logic [8:0] PE_MARK_ERASED_TRACKS = 9'h164;
	localparam logic [7:0] NRZ_MARK_CHAR = 8'h13;
	localparam logic [7:0] NRZ_MARK_CRC = 8'h00;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint CLK_HZ = 200000000;
	localparam longint READ_TIMEOUT_MS = 7000;
	localparam longint WRITE_TIMEOUT_MS = 700;
	localparam longint READ_TIMEOUT_CYCLES = READ_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam longint WRITE_TIMEOUT_CYCLES = WRITE_TIMEOUT_MS * (CLK_HZ / 1000);
	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		TFS_CMD_NONE = 4'h0,
		TFS_CMD_DRIVE_CLEAR = 4'h1,
		TFS_CMD_READ = 4'h2,
		TFS_CMD_SPACE = 4'h3,
		TFS_CMD_WRITE = 4'h4,
		TFS_CMD_WRITE_MARK = 4'h5,
		TFS_CMD_REWIND = 4'h6,
		TFS_CMD_OTHER = 4'h7
	} tfs_cmd_type;
	typedef struct packed {
		logic go;
		tfs_cmd_type code;
	} tfs_command_type;
	typedef struct packed {
		logic tape_mark_detected;
		logic start_marker_sensed;
		logic forward_past_marker;
		logic came_on_line;
		logic medium_on_line;
		logic record_seen;
		logic raw_record_seen;
		logic long_gap;
		logic pe_char_valid;
		logic pe_parity_error;
		logic pe_dead_track_valid;
		logic [3:0] pe_dead_track;
		logic [8:0] pe_char;
		logic nrz_check_valid;
		logic [7:0] nrz_crc_calc;
		logic [7:0] nrz_crc_tape;
	} tfs_transport_type;
	typedef struct packed {
		logic valid;
		logic [8:0] data;
		logic erase_mask_valid;
		logic [8:0] erase_mask;
	} tfs_write_char_type;
endpackage
